// File: src/jtp_pkg.sv
package jtp_pkg;

    localparam int IR_W = 10;
    localparam int DR_W = 32;

    // opcodes: upper four bits are ones, low six bits carry the command
    localparam logic [IR_W-1:0] OP_EXTEST = 10'h3c0;
    localparam logic [IR_W-1:0] OP_SAMPLE = 10'h3c1;
    localparam logic [IR_W-1:0] OP_USER_SCAN_ONE = 10'h3c2;
    localparam logic [IR_W-1:0] OP_USER_SCAN_TWO = 10'h3c3;
    localparam logic [IR_W-1:0] OP_USER_SCAN_THREE = 10'h3e2;
    localparam logic [IR_W-1:0] OP_USER_SCAN_FOUR = 10'h3e3;
    localparam logic [IR_W-1:0] OP_CFG_READBACK = 10'h3c4;
    localparam logic [IR_W-1:0] OP_CFG_WRITE = 10'h3c5;
    localparam logic [IR_W-1:0] OP_INTEST = 10'h3c7;
    localparam logic [IR_W-1:0] OP_USERCODE = 10'h3c8;
    localparam logic [IR_W-1:0] OP_IDCODE = 10'h3c9;
    localparam logic [IR_W-1:0] OP_HIGHZ = 10'h3ca;
    localparam logic [IR_W-1:0] OP_STARTUP_CLOCK = 10'h3cc;
    localparam logic [IR_W-1:0] OP_SHUTDOWN_CLOCK = 10'h3cd;
    localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;

    // fixed capture pattern, low two bits 01
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h011;
    localparam logic [DR_W-1:0] USER_REG_RST = 32'h0000_0000;
    localparam logic [DR_W-1:0] CFG_WORD_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        S_RESET, S_RUN_IDLE,
        S_SEL_DR, S_CAP_DR, S_SHIFT_DR, S_EXIT1_DR, S_PAUSE_DR, S_EXIT2_DR, S_UPD_DR,
        S_SEL_IR, S_CAP_IR, S_SHIFT_IR, S_EXIT1_IR, S_PAUSE_IR, S_EXIT2_IR, S_UPD_IR
    } jtp_state_e;

    typedef enum logic [2:0] {
        DR_BYPASS, DR_IDCODE, DR_USERCODE, DR_CFG_WRITE, DR_CFG_READ, DR_USER
    } jtp_dr_e;

    // user scan instructions are locked out until the device is configured
    function automatic jtp_dr_e jtp_decode(input logic [IR_W-1:0] op, input logic configured);
        jtp_dr_e sel;
        sel = DR_BYPASS;
        case (op)
            OP_IDCODE: sel = DR_IDCODE;
            OP_USERCODE: sel = DR_USERCODE;
            OP_CFG_WRITE: sel = DR_CFG_WRITE;
            OP_CFG_READBACK: sel = DR_CFG_READ;
            OP_USER_SCAN_ONE, OP_USER_SCAN_TWO,
            OP_USER_SCAN_THREE, OP_USER_SCAN_FOUR: sel = configured ? DR_USER : DR_BYPASS;
            default: sel = DR_BYPASS;
        endcase
        return sel;
    endfunction

    function automatic logic [1:0] jtp_user_index(input logic [IR_W-1:0] op);
        return {op[5], op[0]};
    endfunction

endpackage

// File: src/jtp_sync.sv
`timescale 1ns/1ns
module jtp_sync #(
    parameter int W = 1
) (
    input wire logic clk, // destination clock
    input wire logic arst, // async reset, active high
    input wire logic [W-1:0] d, // signals from the other domain
    output logic [W-1:0] q // synchronised copy
);
    logic [W-1:0] meta_q;

    // meta_q feeds only q
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // jtp_sync

// File: src/jtp_tap_ctrl.sv
`timescale 1ns/1ns
// Operation
// - sixteen-state controller advances only on rising tck, steered by sampled tms.
// - five rising tck edges with tms high always reach the reset state.
// - only tck, tms, tdi in and tdo out; no test reset pin.
// - in reset state all test logic is off; device runs normally.
// - capture-ir loads a fixed pattern ending in 01.
// - shift-ir moves captured pattern out and new instruction in.
// - first bit out after pause-ir into shift-ir is zero.
// - update-ir latches the instruction on falling tck; it becomes active.
// - capture-dr loads the register chosen by the active instruction.
// - run-test/idle acts only for instructions that need it.
// - select-dr branches to dr path or select-ir; select-ir to ir path or reset.
// - pause holds contents; exit1 to pause/update, exit2 to shift/update.
// - dr shift, exit, pause, update mirror the ir path on the selected register.
// - decoder supports the standard set, four user registers and configuration access.
// - test port works in any configuration mode and overrides it.
// - user register instructions only after configuration; all others always.
// - 32-bit identification register and configuration register are scannable.
// - instruction register is ten bits, shifted out lsb first.
// - bypass register is one bit, one stage from tdi to tdo.
module jtp_tap_ctrl
    import jtp_pkg::*;
#(
    parameter logic [DR_W-1:0] ID_CODE = 32'h0a5a_5001, // arbitrary value
    parameter logic [DR_W-1:0] USER_CODE = 32'hffff_ffff // arbitrary value
) (
    input wire logic sys_clk, // device clock
    input wire logic rst, // async reset, active high
    input wire logic tck, // test clock from master
    input wire logic tms, // test mode select
    input wire logic tdi, // test data in
    output logic tdo, // test data out
    output logic tdo_oe, // tdo output enable
    input wire logic cfg_done, // device configured, sys_clk level
    input wire logic [DR_W-1:0] cfg_out_word, // readback word, sys_clk domain
    output logic [DR_W-1:0] cfg_in_word, // configuration word written by scan
    output logic cfg_in_valid, // one-cycle strobe with cfg_in_word
    output logic extest, // external test mode active
    output logic intest, // internal test mode active
    output logic highz, // outputs to be tristated
    output logic startup_step, // one startup clock pulse
    output logic shutdown_step // one shutdown clock pulse
);
    logic trst_meta_q;
    logic trst_q;
    jtp_state_e st_q;
    jtp_state_e st_d;
    logic [IR_W-1:0] ir_sr_q;
    logic [IR_W-1:0] ir_hold_q;
    logic pause_seen_q;
    logic bypass_q;
    logic [DR_W-1:0] dr_sr_q;
    logic [DR_W-1:0] usr_q [4];
    logic [DR_W-1:0] cfg_word_q;
    logic cfg_tgl_q;
    logic start_tgl_q;
    logic stop_tgl_q;
    logic [2:0] mode_q;
    logic [DR_W-1:0] rb_q;
    logic rb_seen_q;
    logic done_t;
    logic snap_t;
    jtp_dr_e dr_sel;
    logic [1:0] uidx;
    logic [DR_W-1:0] snap_q;
    logic snap_tgl_q;
    logic s_cfg;
    logic s_start;
    logic s_stop;
    logic s_ack;
    logic [2:0] s_mode;
    logic [2:0] prev_q;
    logic [DR_W-1:0] cfg_in_word_q;
    logic cfg_in_valid_q;
    logic startup_q;
    logic shutdown_q;

    // tck-side reset: asserts at once, releases on tck
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            trst_meta_q <= 1'b1;
            trst_q <= 1'b1;
        end else begin
            trst_meta_q <= 1'b0;
            trst_q <= trst_meta_q;
        end
    end

    jtp_sync #(.W(2)) u_sync_tck (
        .clk(tck),
        .arst(trst_q),
        .d({cfg_done, snap_tgl_q}),
        .q({done_t, snap_t})
    );

    // controller transition table; tms held high walks every state to reset
    // no test reset pin; tms alone walks the controller
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_RESET: st_d = tms ? S_RESET : S_RUN_IDLE;
            S_RUN_IDLE: st_d = tms ? S_SEL_DR : S_RUN_IDLE;
            // branch into dr path or select-ir
            S_SEL_DR: st_d = tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: st_d = tms ? S_EXIT1_DR : S_SHIFT_DR;
            S_SHIFT_DR: st_d = tms ? S_EXIT1_DR : S_SHIFT_DR;
            // dr exits mirror the ir path
            S_EXIT1_DR: st_d = tms ? S_UPD_DR : S_PAUSE_DR;
            S_PAUSE_DR: st_d = tms ? S_EXIT2_DR : S_PAUSE_DR;
            S_EXIT2_DR: st_d = tms ? S_UPD_DR : S_SHIFT_DR;
            S_UPD_DR: st_d = tms ? S_SEL_DR : S_RUN_IDLE;
            // ir path or back to reset
            S_SEL_IR: st_d = tms ? S_RESET : S_CAP_IR;
            S_CAP_IR: st_d = tms ? S_EXIT1_IR : S_SHIFT_IR;
            S_SHIFT_IR: st_d = tms ? S_EXIT1_IR : S_SHIFT_IR;
            // exit1 to pause or update, exit2 to shift or update
            S_EXIT1_IR: st_d = tms ? S_UPD_IR : S_PAUSE_IR;
            S_PAUSE_IR: st_d = tms ? S_EXIT2_IR : S_PAUSE_IR;
            S_EXIT2_IR: st_d = tms ? S_UPD_IR : S_SHIFT_IR;
            S_UPD_IR: st_d = tms ? S_SEL_DR : S_RUN_IDLE;
            default: st_d = S_RESET;
        endcase
    end

    // state moves on rising tck only
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            st_q <= S_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // capture pattern; shift lsb out, tdi in; hold otherwise
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            ir_sr_q <= IR_CAPTURE;
        end else if (st_q == S_CAP_IR) begin
            ir_sr_q <= IR_CAPTURE;
        end else if (st_q == S_SHIFT_IR) begin
            ir_sr_q <= {tdi, ir_sr_q[IR_W-1:1]};
        end
    end

    // remembers that pause-ir was used before the next shift
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            pause_seen_q <= 1'b0;
        end else if (st_q == S_PAUSE_IR) begin
            pause_seen_q <= 1'b1;
        end else if (st_q == S_SHIFT_IR) begin
            pause_seen_q <= 1'b0;
        end
    end

    // instruction latch on falling tck in update-ir
    always_ff @(negedge tck or posedge trst_q) begin
        if (trst_q) begin
            ir_hold_q <= OP_IDCODE;
        end else if (st_q == S_RESET) begin
            ir_hold_q <= OP_IDCODE;
        end else if (st_q == S_UPD_IR) begin
            ir_hold_q <= ir_sr_q;
        end
    end

    // decode to a data register; user access gated by configuration
    assign dr_sel = jtp_decode(ir_hold_q, done_t);
    assign uidx = jtp_user_index(ir_hold_q);

    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            bypass_q <= 1'b0;
        end else if (dr_sel == DR_BYPASS && st_q == S_CAP_DR) begin
            bypass_q <= 1'b0;
        end else if (dr_sel == DR_BYPASS && st_q == S_SHIFT_DR) begin
            bypass_q <= tdi;
        end
    end

    // capture per selected register; shift tdi in on rising tck
    // 32-bit id and configuration registers share this shifter
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            dr_sr_q <= CFG_WORD_RST;
        end else if (st_q == S_CAP_DR) begin
            case (dr_sel)
                DR_IDCODE: dr_sr_q <= ID_CODE;
                DR_USERCODE: dr_sr_q <= USER_CODE;
                DR_CFG_READ: dr_sr_q <= rb_q;
                DR_USER: dr_sr_q <= usr_q[uidx];
                default: dr_sr_q <= CFG_WORD_RST;
            endcase
        end else if (st_q == S_SHIFT_DR && dr_sel != DR_BYPASS) begin
            dr_sr_q <= {tdi, dr_sr_q[DR_W-1:1]};
        end
    end

    // update-dr on falling tck into the selected user register
    generate
        for (genvar gi = 0; gi < 4; gi++) begin : g_user
            always_ff @(negedge tck or posedge trst_q) begin
                if (trst_q) begin
                    usr_q[gi] <= USER_REG_RST;
                end else if (st_q == S_UPD_DR && dr_sel == DR_USER && uidx == 2'(gi)) begin
                    usr_q[gi] <= dr_sr_q;
                end
            end
        end
    endgenerate

    // word stays put until the next update, so the toggle alone crosses
    always_ff @(negedge tck or posedge trst_q) begin
        if (trst_q) begin
            cfg_word_q <= CFG_WORD_RST;
            cfg_tgl_q <= 1'b0;
        end else if (st_q == S_UPD_DR && dr_sel == DR_CFG_WRITE) begin
            cfg_word_q <= dr_sr_q;
            cfg_tgl_q <= ~cfg_tgl_q;
        end
    end

    // tdo updates on falling tck, enabled only in shift states
    always_ff @(negedge tck or posedge trst_q) begin
        if (trst_q) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            case (st_q)
                S_SHIFT_IR: begin
                    tdo <= pause_seen_q ? 1'b0 : ir_sr_q[0];
                    tdo_oe <= 1'b1;
                end
                S_SHIFT_DR: begin
                    tdo <= (dr_sel == DR_BYPASS) ? bypass_q : dr_sr_q[0];
                    tdo_oe <= 1'b1;
                end
                default: tdo_oe <= 1'b0;
            endcase
        end
    end

    // idle steps only for startup and shutdown instructions
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            start_tgl_q <= 1'b0;
            stop_tgl_q <= 1'b0;
        end else if (st_q == S_RUN_IDLE) begin
            start_tgl_q <= start_tgl_q ^ (ir_hold_q == OP_STARTUP_CLOCK);
            stop_tgl_q <= stop_tgl_q ^ (ir_hold_q == OP_SHUTDOWN_CLOCK);
        end
    end

    // test modes override whatever mode the device is in
    // sample/extest/intest during configuration are the master's to avoid
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            mode_q <= 3'h0;
        end else if (st_q == S_RESET) begin
            mode_q <= 3'h0;
        end else begin
            mode_q <= {ir_hold_q == OP_EXTEST, ir_hold_q == OP_INTEST, ir_hold_q == OP_HIGHZ};
        end
    end

    // readback word copied only after its toggle has been synchronised
    always_ff @(posedge tck or posedge trst_q) begin
        if (trst_q) begin
            rb_q <= CFG_WORD_RST;
            rb_seen_q <= 1'b0;
        end else if (snap_t != rb_seen_q) begin
            rb_q <= snap_q;
            rb_seen_q <= snap_t;
        end
    end

    jtp_sync #(.W(7)) u_sync_sys (
        .clk(sys_clk),
        .arst(rst),
        .d({cfg_tgl_q, start_tgl_q, stop_tgl_q, rb_seen_q, mode_q}),
        .q({s_cfg, s_start, s_stop, s_ack, s_mode})
    );

    // new snapshot only after tck side acknowledged the previous one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            snap_q <= CFG_WORD_RST;
            snap_tgl_q <= 1'b0;
        end else if (s_ack == snap_tgl_q) begin
            snap_q <= cfg_out_word;
            snap_tgl_q <= ~snap_tgl_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 3'h0;
            cfg_in_valid_q <= 1'b0;
            startup_q <= 1'b0;
            shutdown_q <= 1'b0;
        end else begin
            prev_q <= {s_cfg, s_start, s_stop};
            cfg_in_valid_q <= s_cfg ^ prev_q[2];
            startup_q <= s_start ^ prev_q[1];
            shutdown_q <= s_stop ^ prev_q[0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_in_word_q <= CFG_WORD_RST;
        end else if (s_cfg ^ prev_q[2]) begin
            cfg_in_word_q <= cfg_word_q;
        end
    end

    assign cfg_in_word = cfg_in_word_q;
    assign cfg_in_valid = cfg_in_valid_q;
    assign startup_step = startup_q;
    assign shutdown_step = shutdown_q;
    assign extest = s_mode[2];
    assign intest = s_mode[1];
    assign highz = s_mode[0];

    AST_FIVE_TMS_RESET: assert property (
        @(posedge tck) disable iff (trst_q) tms [*5] |=> st_q == S_RESET)
        else $error("five tms-high edges did not reach reset");
    AST_CAPTURE_IR: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_CAP_IR |=> ir_sr_q[1:0] == 2'b01)
        else $error("capture-ir pattern low bits not 01");
    AST_TDO_DRIVE: assert property (
        @(posedge tck) disable iff (trst_q) $past(st_q) == st_q |-> tdo_oe == (st_q == S_SHIFT_IR || st_q == S_SHIFT_DR))
        else $error("tdo enable outside shift states");
    // the bit sampled at the first shift-ir edge is the one launched on the falling edge after entering shift-ir
    AST_PAUSE_ZERO: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_EXIT2_IR && !tms |=> tdo == 1'b0)
        else $error("first bit after pause-ir not zero");
    AST_PAUSE_HOLD: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_PAUSE_IR |=> $stable(ir_sr_q))
        else $error("instruction shifter moved in pause");
    AST_UPDATE_IR: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_UPD_IR |=> ir_hold_q == $past(ir_sr_q))
        else $error("update-ir did not latch the instruction");
    AST_RESET_IDCODE: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_RESET ##1 st_q == S_RESET |-> ir_hold_q == OP_IDCODE)
        else $error("reset state did not select idcode");
    AST_BYPASS_STAGE: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_SHIFT_DR && dr_sel == DR_BYPASS |=> bypass_q == $past(tdi))
        else $error("bypass stage did not take tdi");
    AST_USER_LOCK: assert property (
        @(posedge tck) disable iff (trst_q) !done_t |-> dr_sel != DR_USER)
        else $error("user register reachable before configuration");
    AST_RESET_QUIET: assert property (
        @(posedge tck) disable iff (trst_q) st_q == S_RESET ##1 st_q == S_RESET |=> mode_q == 3'h0)
        else $error("test mode active in reset state");

endmodule // jtp_tap_ctrl

// File: verif/jtp_master.sv
`timescale 1ns/1ns
module jtp_master (
    output logic tck, // test clock, runs only inside frames
    output logic tms, // mode select
    output logic tdi, // serial data to the port
    input wire logic tdo, // serial data from the port
    input wire logic tdo_oe // port drives tdo
);
    // tms and tdi start high, as their pull-ups would leave them; tck starts low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one tck period; lines move after the falling edge, tdo is taken at the rising edge
    task automatic step(input logic m, input logic d, output logic o, output logic oe);
        tms = m;
        tdi = d;
        #6;
        tck = 1'b1;
        o = tdo;
        oe = tdo_oe;
        #6;
        tck = 1'b0;
    endtask

    task automatic go(input logic m);
        logic o;
        logic oe;
        step(m, 1'b1, o, oe);
    endtask

    task automatic tap_reset();
        repeat (5) go(1'b1);
    endtask

    // starts and ends in run-idle; 0 < pz < n parks in pause after that many bits
    task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pz,
                        output logic [31:0] dout, output logic oe_all);
        logic o;
        logic oe;
        dout = 32'h0000_0000;
        oe_all = 1'b1;
        go(1'b1);
        if (ir) begin
            go(1'b1);
        end
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++) begin
            step((i == n - 1) || (i + 1 == pz), din[i], o, oe);
            dout[i] = o;
            oe_all = oe_all & oe;
            if ((i + 1 == pz) && (i < n - 1)) begin
                go(1'b0);
                go(1'b1);
                go(1'b0);
            end
        end
        go(1'b1);
        go(1'b0);
    endtask
endmodule // jtp_master

// File: verif/test_jtag_tap_controller.sv
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_jtag_tap_controller;
    import jtp_pkg::*;
    typedef struct {
        logic [IR_W-1:0] op;
        logic [DR_W-1:0] din;
        logic [DR_W-1:0] exp;
        logic [DR_W-1:0] mask;
        logic [2:0] modes;
    } jtp_row_s;
    localparam logic [DR_W-1:0] ID_V = 32'h1234_5001; // arbitrary value
    localparam logic [DR_W-1:0] UC_V = 32'h0077_e3a1; // arbitrary value
    localparam logic [DR_W-1:0] RB_V = 32'h5a0f_3c96;
    localparam logic [DR_W-1:0] BP_IN = 32'h1357_9bdf;
    localparam logic [DR_W-1:0] BP_X = {BP_IN[30:0], 1'b0};
    localparam logic [DR_W-1:0] ALL = 32'hffff_ffff;
    localparam logic [DR_W-1:0] BPM = 32'hffff_fffe;
    logic sys_clk;
    logic rst;
    logic cfg_done;
    logic [DR_W-1:0] cfg_out_word;
    logic tck, tms, tdi, tdo, tdo_oe, cfg_in_valid, extest, intest, highz, startup_step, shutdown_step;
    logic [DR_W-1:0] cfg_in_word;
    logic [DR_W-1:0] got_word;
    logic [DR_W-1:0] dout;
    logic oe_all;
    int n_errors = 0;
    int tests_run = 0;
    int n_valid = 0;
    int n_start = 0;
    int n_stop = 0;
    // bypass capture bit is left unchecked: only the one-stage delay matters
    jtp_row_s rows[17] = '{
        '{OP_IDCODE, 32'h0000_0000, ID_V, ALL, 3'b000},
        '{OP_USERCODE, 32'h0000_0000, UC_V, ALL, 3'b000},
        '{OP_BYPASS, BP_IN, BP_X, BPM, 3'b000},
        '{10'h3fe, BP_IN, BP_X, BPM, 3'b000},
        '{OP_EXTEST, BP_IN, BP_X, BPM, 3'b100},
        '{OP_SAMPLE, BP_IN, BP_X, BPM, 3'b000},
        '{OP_INTEST, BP_IN, BP_X, BPM, 3'b010},
        '{OP_HIGHZ, BP_IN, BP_X, BPM, 3'b001},
        '{OP_CFG_READBACK, 32'h0000_0000, RB_V, ALL, 3'b000},
        '{OP_USER_SCAN_ONE, 32'ha1a1_0001, USER_REG_RST, ALL, 3'b000},
        '{OP_USER_SCAN_TWO, 32'ha1a1_0002, USER_REG_RST, ALL, 3'b000},
        '{OP_USER_SCAN_THREE, 32'ha1a1_0003, USER_REG_RST, ALL, 3'b000},
        '{OP_USER_SCAN_FOUR, 32'ha1a1_0004, USER_REG_RST, ALL, 3'b000},
        '{OP_USER_SCAN_ONE, 32'h0000_0000, 32'ha1a1_0001, ALL, 3'b000},
        '{OP_USER_SCAN_TWO, 32'h0000_0000, 32'ha1a1_0002, ALL, 3'b000},
        '{OP_USER_SCAN_THREE, 32'h0000_0000, 32'ha1a1_0003, ALL, 3'b000},
        '{OP_USER_SCAN_FOUR, 32'h0000_0000, 32'ha1a1_0004, ALL, 3'b000}
    };

    always #4 sys_clk = ~sys_clk;

    jtp_tap_ctrl #(.ID_CODE(ID_V), .USER_CODE(UC_V)) jtp_tap_ctrl_i (
        .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .cfg_done(cfg_done), .cfg_out_word(cfg_out_word), .cfg_in_word(cfg_in_word),
        .cfg_in_valid(cfg_in_valid), .extest(extest), .intest(intest), .highz(highz),
        .startup_step(startup_step), .shutdown_step(shutdown_step)
    );

    jtp_master jtp_master_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    always @(posedge sys_clk) begin
        if (cfg_in_valid === 1'b1) begin
            n_valid++;
            got_word = cfg_in_word;
        end
        if (startup_step === 1'b1) n_start++;
        if (shutdown_step === 1'b1) n_stop++;
    end

    always @(tdo) begin
        if (rst === 1'b0) `CHK(tck, 1'b0)
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic load_ir(input logic [IR_W-1:0] op);
        jtp_master_i.scan(1'b1, IR_W, {22'h0, op}, 0, dout, oe_all);
        `CHK(dout[IR_W-1:0], IR_CAPTURE)
        `CHK(oe_all, 1'b1)
    endtask

    task automatic scan_dr(input logic [DR_W-1:0] din, input int pz);
        jtp_master_i.scan(1'b0, DR_W, din, pz, dout, oe_all);
        `CHK(tdo_oe, 1'b0)
    endtask

    initial begin
        #500000;
        n_errors++;
        final_report();
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        cfg_done = 1'b0;
        cfg_out_word = RB_V;
        #3;
        jtp_master_i.tap_reset();
        `CHK({tdo_oe, extest, intest, highz, cfg_in_valid}, 5'h00)
        @(posedge sys_clk) rst <= 1'b0;
        jtp_master_i.tap_reset();
        jtp_master_i.go(1'b0);
        scan_dr(32'h0000_0000, 0);
        `CHK(dout, ID_V)
        load_ir(OP_USER_SCAN_TWO);
        scan_dr(BP_IN, 0);
        `CHK(dout & BPM, BP_X)
        @(posedge sys_clk) cfg_done <= 1'b1;
        wait_clk(6);
        foreach (rows[k]) begin
            load_ir(rows[k].op);
            scan_dr(rows[k].din, 0);
            `CHK(dout & rows[k].mask, rows[k].exp & rows[k].mask)
            wait_clk(6);
            `CHK({extest, intest, highz}, rows[k].modes)
        end
        // tms reset from the middle of a data shift
        load_ir(OP_EXTEST);
        repeat (4) jtp_master_i.go(1'b0);
        jtp_master_i.go(1'b1);
        repeat (4) jtp_master_i.go(1'b0);
        jtp_master_i.tap_reset();
        jtp_master_i.go(1'b0);
        wait_clk(6);
        `CHK({extest, intest, highz}, 3'b000)
        scan_dr(32'h0000_0000, 8);
        `CHK(dout, ID_V)
        scan_dr(32'h0000_0000, 8);
        `CHK(dout, ID_V)
        jtp_master_i.scan(1'b1, IR_W, {22'h0, OP_BYPASS}, 4, dout, oe_all);
        `CHK(dout[3:0], IR_CAPTURE[3:0])
        `CHK(dout[4], 1'b0)
        jtp_master_i.tap_reset();
        jtp_master_i.go(1'b0);
        load_ir(OP_CFG_WRITE);
        n_valid = 0;
        scan_dr(32'hc0f1_9a27, 0);
        for (int i = 0; i < 20 && n_valid == 0; i++) @(posedge sys_clk);
        `CHK(n_valid, 1)
        if (n_valid == 0) final_report();
        `CHK(got_word, 32'hc0f1_9a27)
        `CHK(n_start + n_stop, 0)
        load_ir(OP_STARTUP_CLOCK);
        n_start = 0;
        repeat (5) jtp_master_i.go(1'b0);
        wait_clk(8);
        `CHK(n_start, 5)
        jtp_master_i.tap_reset();
        jtp_master_i.go(1'b0);
        load_ir(OP_SHUTDOWN_CLOCK);
        n_stop = 0;
        repeat (3) jtp_master_i.go(1'b0);
        wait_clk(8);
        `CHK(n_stop, 3)
        // a new readback word must reach capture-dr through the snapshot handshake
        @(posedge sys_clk) cfg_out_word <= 32'h3c96_a50f;
        wait_clk(4);
        load_ir(OP_CFG_READBACK);
        scan_dr(32'h0000_0000, 0);
        `CHK(dout, 32'h3c96_a50f)
        final_report();
    end
endmodule // test_jtag_tap_controller
